// ---- bench/serdes_tx_strap_control_tb_top.sv ----
// self-checking bench for the strap decoder and pin-function control
`default_nettype none
module serdes_tx_strap_control_tb_top import stc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, reset, pin_function_select, link_side_select, emphasis_strap, width_strap;
  logic       field_test_entry, scl_in, lvds_de, bc_lock_n, bc_hot_plug_n, reg_wr, reg_rd;
  logic       lock_cmd, hpd_cmd, de_cmd, scl_low, lock_detect_n, hot_plug_detect_n;
  logic       lock_from_backchannel, bc_master_side, i2c_is_slave, serial_addr_bad;
  logic       sublink_power_on, mainlink_power_on, emphasis_full, width_24bit, sel_de;
  logic       in_field_bit_error_test, send_video;
  logic [1:0] serial_addr_strap, lane_mode_strap, power_down_straps;
  logic [3:0] gpio_in, reg_addr, gpio_out, gpio_oe_n;
  logic [7:0] int_src, reg_wdata, reg_rdata, d;
  logic [6:0] serial_addr;
  stc_lane_t  lane_mode;
  int         errors, cmp_count;
  stc_top i_dut (.clk, .reset, .pin_function_select, .link_side_select, .serial_addr_strap,
    .lane_mode_strap, .power_down_straps, .emphasis_strap, .width_strap, .field_test_entry,
    .scl_in, .lvds_de, .gpio_in, .bc_lock_n, .bc_hot_plug_n, .int_src, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .gpio_out, .gpio_oe_n, .lock_detect_n, .hot_plug_detect_n,
    .lock_from_backchannel, .bc_master_side, .i2c_is_slave, .serial_addr, .serial_addr_bad,
    .lane_mode, .sublink_power_on, .mainlink_power_on, .emphasis_full, .width_24bit,
    .in_field_bit_error_test, .sel_de, .send_video);
  stc_far_model i_far (.clk, .reset, .pin_function_select, .link_side_select, .serial_addr_strap,
    .lock_cmd, .hpd_cmd, .de_cmd, .scl_low, .bc_lock_n, .bc_hot_plug_n, .lvds_de, .scl_in,
    .peer_side(), .peer_addr());
  always #2 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic t_straps;
    logic [7:0] amap [4] = '{8'h0b, 8'h74, 8'h77, 8'h80};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {serial_addr_strap, lane_mode_strap, power_down_straps} <= {3{i[1:0]}};
      {emphasis_strap, width_strap, field_test_entry, link_side_select} <= {4{i[0]}};
      settle;
      check({serial_addr_bad, serial_addr}, amap[i]);
      check({6'h0, lane_mode}, 8'(i));
      check({1'b0, sublink_power_on, mainlink_power_on, emphasis_full, width_24bit,
        in_field_bit_error_test, bc_master_side, i2c_is_slave},
        {1'b0, i[1:0], {3{i[0]}}, {2{~i[0]}}});
    end
  endtask
  task automatic t_pins;
    @(posedge clk);
    pin_function_select <= 1'b1;
    settle;
    check({gpio_oe_n, gpio_out}, 8'hf0);
    @(posedge clk);
    pin_function_select <= 1'b0;
    gpio_in <= 4'h2;
    wr(OFS_GPIO_DIR, 8'h03);
    settle;
    check({4'h0, lock_detect_n, hot_plug_detect_n, gpio_oe_n[1:0]}, 8'h07);
    @(posedge clk);
    pin_function_select <= 1'b1;
    lock_cmd <= 1'b1;
    gpio_in <= 4'h1;
    settle;
    check({1'b0, lock_detect_n, hot_plug_detect_n, lock_from_backchannel, gpio_oe_n[1:0],
      gpio_out[1:0]}, 8'h30);
    wr(OFS_GPIO_OUT, 8'h03);
    settle;
    check({gpio_oe_n, gpio_out}, 8'hf0);
  endtask
  task automatic t_int;
    @(posedge clk);
    link_side_select <= 1'b0;
    gpio_in <= 4'h0;
    settle;
    check({6'h0, gpio_out[2], gpio_oe_n[2]}, 8'h01);
    wr(OFS_INT_STAT, 8'hff);
    wr(OFS_INT_MASK, 8'h11);
    @(posedge clk);
    gpio_in <= 4'h1;
    settle;
    check({6'h0, gpio_out[2], gpio_oe_n[2]}, 8'h00);
    rd(OFS_INT_STAT);
    check(d, 8'h01);
    wr(OFS_INT_STAT, 8'h01);
    @(posedge clk);
    int_src <= 8'h10;
    @(posedge clk);
    int_src <= 8'h00;
    settle;
    check({7'h0, gpio_oe_n[2]}, 8'h00);
    wr(OFS_INT_STAT, 8'h10);
    settle;
    check({7'h0, gpio_oe_n[2]}, 8'h01);
    @(posedge clk);
    int_src <= 8'h10;
    reg_addr <= OFS_INT_STAT;
    reg_wdata <= 8'h10;
    reg_wr <= 1'b1;
    @(posedge clk);
    int_src <= 8'h00;
    reg_wr <= 1'b0;
    settle;
    check({7'h0, gpio_oe_n[2]}, 8'h00);
    rd(4'hf);
    check(d, 8'h00);
  endtask
  task automatic t_de;
    @(posedge clk);
    power_down_straps <= 2'h1;
    de_cmd <= 1'b1;
    settle;
    check({6'h0, sel_de, send_video}, 8'h03);
    @(posedge clk);
    scl_low <= 1'b1;
    settle;
    check({6'h0, sel_de, send_video}, 8'h00);
    @(posedge clk);
    gpio_in <= 4'h8;
    de_cmd <= 1'b0;
    power_down_straps <= 2'h3;
    settle;
    check({7'h0, sel_de}, 8'h00);
    wr(OFS_DE_CTRL, 8'h01);
    settle;
    check({7'h0, sel_de}, 8'h01);
    wr(OFS_DE_CTRL, 8'h03);
    settle;
    check({7'h0, sel_de}, 8'h00);
  endtask
  task automatic t_gp2;
    @(posedge clk);
    link_side_select <= 1'b1;
    wr(OFS_GPIO_DIR, 8'h04);
    wr(OFS_GPIO_OUT, 8'h00);
    settle;
    check({6'h0, gpio_out[2], gpio_oe_n[2]}, 8'h00);
    wr(OFS_GPIO_OUT, 8'h04);
    settle;
    check({6'h0, gpio_out[2], gpio_oe_n[2]}, 8'h03);
    wr(OFS_DE_CTRL, 8'h04);
    settle;
    check({6'h0, gpio_out[2], gpio_oe_n[2]}, 8'h02);
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    errors = 0;
    cmp_count = 0;
    {pin_function_select, link_side_select, emphasis_strap, width_strap, field_test_entry} = '0;
    {reg_wr, reg_rd, lock_cmd, hpd_cmd, de_cmd, scl_low} = '0;
    {serial_addr_strap, lane_mode_strap, power_down_straps, gpio_in, reg_addr} = '0;
    {int_src, reg_wdata} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_straps;
    t_pins;
    t_int;
    t_de;
    t_gp2;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize;
  end
endmodule
`default_nettype wire

// ---- bench/stc_far_model.sv ----
// far-side model: receiver backchannel states, stream de and host clock pin
`default_nettype none
module stc_far_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       pin_function_select,
  input  wire logic       link_side_select,
  input  wire logic [1:0] serial_addr_strap,
  input  wire logic       lock_cmd,
  input  wire logic       hpd_cmd,
  input  wire logic       de_cmd,
  input  wire logic       scl_low,
  output var  logic       bc_lock_n,
  output var  logic       bc_hot_plug_n,
  output var  logic       lvds_de,
  output var  logic       scl_in,
  output var  logic       peer_side,
  output var  logic [1:0] peer_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // states sent over backchannel only when selected
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bc_lock_n     <= 1'b1;
      bc_hot_plug_n <= 1'b1;
      lvds_de       <= 1'b0;
    end else begin
      bc_lock_n     <= !(lock_cmd && pin_function_select);
      bc_hot_plug_n <= !(hpd_cmd && pin_function_select);
      lvds_de       <= de_cmd;
    end
  end
  // host pulls clock low to pick external de, pull-up otherwise
  assign scl_in = !scl_low;
  // peer strapped to opposite side and same address
  assign peer_side = !link_side_select;
  assign peer_addr = serial_addr_strap;
endmodule
`default_nettype wire

// ---- bench/stc_top_monitor.sv ----
// assertion checker on the strap decoder ports
`default_nettype none
module stc_top_monitor import stc_pkg::*; (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       pin_function_select,
  input wire logic       link_side_select,
  input wire logic [1:0] serial_addr_strap,
  input wire logic [1:0] lane_mode_strap,
  input wire logic [1:0] power_down_straps,
  input wire logic       emphasis_strap,
  input wire logic       field_test_entry,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe_n,
  input wire logic       lock_from_backchannel,
  input wire logic       bc_master_side,
  input wire logic       i2c_is_slave,
  input wire logic [6:0] serial_addr,
  input wire stc_lane_t  lane_mode,
  input wire logic       sublink_power_on,
  input wire logic       mainlink_power_on,
  input wire logic       emphasis_full,
  input wire logic       in_field_bit_error_test,
  input wire logic       sel_de,
  input wire logic       send_video
);
  localparam logic [6:0] AMAP [4] = '{7'h0b, 7'h74, 7'h77, 7'h00};
  logic [1:0] up_r;
  logic       ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // decoded outputs valid three edges after release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  assign ok = (up_r == 2'h3);
  emph_copy_a: assert property (ok |-> emphasis_full == $past(emphasis_strap, 3))
    else $error("emphasis level wrong");
  test_entry_a: assert property (ok && $rose(field_test_entry) |-> ##3 in_field_bit_error_test)
    else $error("test entry late");
  power_copy_a: assert property (ok |-> {sublink_power_on, mainlink_power_on} == $past(power_down_straps, 3))
    else $error("power state wrong");
  addr_map_a: assert property (ok |-> serial_addr == AMAP[$past(serial_addr_strap, 3)])
    else $error("serial address wrong");
  lane_map_a: assert property (ok |-> lane_mode == stc_lane_t'($past(lane_mode_strap, 3)))
    else $error("lane mode wrong");
  role_sel_a: assert property (ok |-> bc_master_side != $past(link_side_select, 3) && i2c_is_slave == bc_master_side)
    else $error("role wrong");
  lock_pin_a: assert property (ok && !$past(pin_function_select, 3) |-> gpio_oe_n[1:0] == 2'h3)
    else $error("shared pins driven");
  bc_flag_a: assert property (ok |-> lock_from_backchannel == $past(pin_function_select, 3))
    else $error("backchannel flag wrong");
  open_drain_a: assert property (gpio_out[1:0] == 2'h0)
    else $error("pins driven high");
  de_input_a: assert property (gpio_oe_n[3])
    else $error("de pin driven");
  video_gate_a: assert property (!mainlink_power_on |-> !send_video)
    else $error("video while powered down");
  cover property (sel_de && send_video);
  cover property (!gpio_oe_n[2]);
  cover property (in_field_bit_error_test);
endmodule
bind stc_top stc_top_monitor i_mon (.clk, .reset, .pin_function_select, .link_side_select,
  .serial_addr_strap, .lane_mode_strap, .power_down_straps, .emphasis_strap, .field_test_entry,
  .gpio_out, .gpio_oe_n, .lock_from_backchannel, .bc_master_side, .i2c_is_slave, .serial_addr,
  .lane_mode, .sublink_power_on, .mainlink_power_on, .emphasis_full, .in_field_bit_error_test,
  .sel_de, .send_video);
`default_nettype wire

// ---- rtl/stc_pkg.sv ----
// constants for the serializer strap decoder and pin-function control
`default_nettype none
package stc_pkg;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned ADDR_W      = 7;
  localparam logic [6:0]  ADDR_LL     = 7'h0b;
  localparam logic [6:0]  ADDR_LH     = 7'h74;
  localparam logic [6:0]  ADDR_HL     = 7'h77;
  localparam logic [6:0]  ADDR_BAD    = 7'h00;
  // register offsets of this block's own control and status words
  localparam logic [3:0]  OFS_GPIO_DIR  = 4'h0;
  localparam logic [3:0]  OFS_GPIO_OUT  = 4'h1;
  localparam logic [3:0]  OFS_INT_MASK  = 4'h2;
  localparam logic [3:0]  OFS_INT_STAT  = 4'h3;
  localparam logic [3:0]  OFS_DE_CTRL   = 4'h4;
  localparam logic [3:0]  OFS_GPIO_IN   = 4'h5;
  localparam logic [3:0]  OFS_STRAPS   = 4'h6;
  // field positions
  localparam int unsigned DE_EN_BIT   = 0;
  localparam int unsigned DE_POL_BIT  = 1;
  localparam int unsigned GP2_PP_BIT  = 2;
  localparam int unsigned STAT_LOCK   = 4;
  localparam int unsigned STAT_HPD    = 5;
  // reset values
  localparam logic [3:0]  GPIO_DIR_RST = 4'h0;
  localparam logic [3:0]  GPIO_OUT_RST = 4'h0;
  localparam logic [7:0]  INT_MASK_RST = 8'h00;
  localparam logic [7:0]  DE_CTRL_RST  = 8'h00;
  typedef enum logic [1:0] {STC_LANE_DDO, STC_LANE_SO, STC_LANE_DO, STC_LANE_BAD} stc_lane_t;
  typedef enum {STC_DE_LVDS, STC_DE_EXT, STC_DE_EXT_INV} stc_de_src_t;
endpackage
`default_nettype wire

// ---- rtl/stc_sync.sv ----
// multi-stage level synchroniser for a bus of straps
`default_nettype none
module stc_sync #(
  parameter int unsigned WIDTH  = 8,
  parameter int unsigned STAGES = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stg_r [STAGES];
  if (STAGES < 2) begin : g_bad_stages
    $error("stc_sync needs two stages");
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < STAGES; i++) stg_r[i] <= '0;
    end else begin
      stg_r[0] <= d;
      for (int i = 1; i < STAGES; i++) stg_r[i] <= stg_r[i-1];
    end
  end
  assign q = stg_r[STAGES-1];
endmodule
`default_nettype wire

// ---- rtl/stc_top.sv ----
// strap decode, pin-function mux and data-enable source selection
//
// Implementation choices: strobed register access and the address map.
`default_nettype none
module stc_top (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   pin_function_select,
  input  wire logic                   link_side_select,
  input  wire logic [1:0]             serial_addr_strap,
  input  wire logic [1:0]             lane_mode_strap,
  input  wire logic [1:0]             power_down_straps,
  input  wire logic                   emphasis_strap,
  input  wire logic                   width_strap,
  input  wire logic                   field_test_entry,
  input  wire logic                   scl_in,
  input  wire logic                   lvds_de,
  input  wire logic [3:0]             gpio_in,
  input  wire logic                   bc_lock_n,
  input  wire logic                   bc_hot_plug_n,
  input  wire logic [7:0]             int_src,
  input  wire logic [3:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  output logic [3:0]                  gpio_out,
  output logic [3:0]                  gpio_oe_n,
  output logic                        lock_detect_n,
  output logic                        hot_plug_detect_n,
  output logic                        lock_from_backchannel,
  output logic                        bc_master_side,
  output logic                        i2c_is_slave,
  output logic [stc_pkg::ADDR_W-1:0]  serial_addr,
  output logic                        serial_addr_bad,
  output stc_pkg::stc_lane_t          lane_mode,
  output logic                        sublink_power_on,
  output logic                        mainlink_power_on,
  output logic                        emphasis_full,
  output logic                        width_24bit,
  output logic                        in_field_bit_error_test,
  output logic                        sel_de,
  output logic                        send_video
);
  import stc_pkg::*;

  localparam int unsigned NSTRAP = 12;
  localparam int unsigned NLIVE  = 7;

  logic [NSTRAP-1:0] strap_raw;
  logic [NSTRAP-1:0] strap_s;
  logic [NLIVE-1:0]  live_raw;
  logic [NLIVE-1:0]  live_s;

  assign strap_raw = {pin_function_select, link_side_select, serial_addr_strap,
                      lane_mode_strap, power_down_straps, emphasis_strap, width_strap,
                      field_test_entry, scl_in};
  assign live_raw  = {gpio_in, lvds_de, bc_lock_n, bc_hot_plug_n};

  stc_sync #(.WIDTH(NSTRAP), .STAGES(SYNC_STAGES)) u_strap_sync (
    .clk   (clk),
    .reset (reset),
    .d     (strap_raw),
    .q     (strap_s)
  );
  stc_sync #(.WIDTH(NLIVE), .STAGES(SYNC_STAGES)) u_live_sync (
    .clk   (clk),
    .reset (reset),
    .d     (live_raw),
    .q     (live_s)
  );

  logic       s_pin_function_select, s_side, s_emph, s_width, s_test, s_scl;
  logic [1:0] s_ain, s_mode, s_pdn;
  logic [3:0] s_gpio;
  logic       s_lvds_de, s_bc_lock, s_bc_hpd;
  assign {s_pin_function_select, s_side, s_ain, s_mode, s_pdn, s_emph, s_width, s_test, s_scl} = strap_s;
  assign {s_gpio, s_lvds_de, s_bc_lock, s_bc_hpd} = live_s;

  typedef struct packed {
    logic [3:0]  gpio_dir;
    logic [3:0]  gpio_val;
    logic [7:0]  int_mask;
    logic [7:0]  int_stat;
    logic [7:0]  de_ctrl;
    logic [3:0]  gpio_prev;
    logic [1:0]  warm;
    logic [7:0]  rdata;
    logic [3:0]  gout;
    logic [3:0]  goe_n;
    logic        lock_n;
    logic        hpd_n;
    logic        lock_bc;
    logic        master;
    logic        i2c_slave;
    logic [6:0]  addr;
    logic        addr_bad;
    stc_lane_t   lane;
    logic        sub_on;
    logic        main_on;
    logic        emph;
    logic        w24;
    logic        test;
    logic        de;
    logic        video;
  } stc_state_t;

  stc_state_t st_r, st_nxt;
  logic [7:0]  ev;
  logic [7:0]  strap_word;
  logic        ext_de;
  stc_de_src_t de_src;

  assign strap_word = {s_test, s_width, s_emph, s_pdn, s_mode, s_pin_function_select};

  always_comb begin
    st_nxt = st_r;
    // events: gp input edges in low nibble, internal statuses above
    // pin edges ignored until the sync pipe holds real levels
    st_nxt.warm = (st_r.warm == 2'h3) ? 2'h3 : st_r.warm + 2'h1;
    ev = {int_src[7:4], (st_r.warm == 2'h3) ? (s_gpio ^ st_r.gpio_prev) : 4'h0}
         | {int_src[3:0], 4'h0};
    st_nxt.gpio_prev = s_gpio;

    // register port
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_GPIO_DIR: st_nxt.rdata = {4'h0, st_r.gpio_dir};
        OFS_GPIO_OUT: st_nxt.rdata = {4'h0, st_r.gpio_val};
        OFS_INT_MASK: st_nxt.rdata = st_r.int_mask;
        OFS_INT_STAT: st_nxt.rdata = st_r.int_stat;
        OFS_DE_CTRL:  st_nxt.rdata = st_r.de_ctrl;
        OFS_GPIO_IN:  st_nxt.rdata = {2'h0, s_bc_hpd, s_bc_lock, s_gpio};
        OFS_STRAPS:   st_nxt.rdata = strap_word;
        default:      st_nxt.rdata = 8'h00;
      endcase
    end
    // status: write one to clear, new event wins
    if (reg_wr && reg_addr == OFS_INT_STAT) begin
      st_nxt.int_stat = st_r.int_stat & ~reg_wdata;
    end
    st_nxt.int_stat = st_nxt.int_stat | ev;
    if (reg_wr) begin
      case (reg_addr)
        OFS_GPIO_DIR: st_nxt.gpio_dir = reg_wdata[3:0];
        OFS_GPIO_OUT: st_nxt.gpio_val = reg_wdata[3:0];
        OFS_INT_MASK: st_nxt.int_mask = reg_wdata;
        OFS_DE_CTRL:  st_nxt.de_ctrl  = reg_wdata;
        default:      st_nxt.int_mask = st_nxt.int_mask;
      endcase
    end

    st_nxt.master    = !s_side;
    st_nxt.i2c_slave = !s_side;
    st_nxt.addr_bad = 1'b0;
    case (s_ain)
      2'b00:   st_nxt.addr = ADDR_LL;
      2'b01:   st_nxt.addr = ADDR_LH;
      2'b10:   st_nxt.addr = ADDR_HL;
      default: begin
        st_nxt.addr     = ADDR_BAD;
        st_nxt.addr_bad = 1'b1;
      end
    endcase
    case (s_mode)
      2'b00:   st_nxt.lane = STC_LANE_DDO;
      2'b01:   st_nxt.lane = STC_LANE_SO;
      2'b10:   st_nxt.lane = STC_LANE_DO;
      default: st_nxt.lane = STC_LANE_BAD;
    endcase
    st_nxt.sub_on  = s_pdn[1];
    st_nxt.main_on = s_pdn[0];
    st_nxt.emph = s_emph;
    st_nxt.w24 = s_width;
    st_nxt.test = s_test;

    // gp pins 0,1: inputs, or open-drain low only
    st_nxt.lock_bc = s_pin_function_select;
    for (int i = 0; i < 2; i++) begin
      st_nxt.gout[i]  = 1'b0;
      st_nxt.goe_n[i] = !(s_pin_function_select && st_r.gpio_dir[i] && !st_r.gpio_val[i]);
    end
    // lock/hot-plug via backchannel when select high
    st_nxt.lock_n = s_pin_function_select ? s_bc_lock : s_gpio[0];
    st_nxt.hpd_n  = s_pin_function_select ? s_bc_hpd  : s_gpio[1];

    if (!s_side) begin
      st_nxt.gout[2]  = 1'b0;
      st_nxt.goe_n[2] = !(|(st_nxt.int_stat & st_r.int_mask));
    end else if (st_r.gpio_dir[2]) begin
      st_nxt.gout[2]  = st_r.gpio_val[2];
      st_nxt.goe_n[2] = st_r.de_ctrl[GP2_PP_BIT] ? 1'b0 : st_r.gpio_val[2];
    end else begin
      st_nxt.gout[2]  = 1'b0;
      st_nxt.goe_n[2] = 1'b1;
    end

    // pin 3 stays input while used as de
    st_nxt.gout[3]  = 1'b0;
    st_nxt.goe_n[3] = 1'b1;
    ext_de = s_gpio[3];
    de_src = STC_DE_LVDS;
    if (s_pdn == 2'b01) begin
      de_src = s_scl ? STC_DE_LVDS : STC_DE_EXT;
    end else if (s_pdn == 2'b11 && st_r.de_ctrl[DE_EN_BIT]) begin
      de_src = st_r.de_ctrl[DE_POL_BIT] ? STC_DE_EXT_INV : STC_DE_EXT;
    end
    case (de_src)
      STC_DE_EXT:     st_nxt.de = ext_de;
      STC_DE_EXT_INV: st_nxt.de = !ext_de;
      default:        st_nxt.de = s_lvds_de;
    endcase
    st_nxt.video = st_nxt.de && s_pdn[0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r          <= '0;
      st_r.gpio_dir <= GPIO_DIR_RST;
      st_r.gpio_val <= GPIO_OUT_RST;
      st_r.int_mask <= INT_MASK_RST;
      st_r.de_ctrl  <= DE_CTRL_RST;
      st_r.goe_n    <= 4'hf;
      st_r.lock_n   <= 1'b1;
      st_r.hpd_n    <= 1'b1;
      st_r.lane     <= STC_LANE_DDO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata               = st_r.rdata;
  assign gpio_out                = st_r.gout;
  assign gpio_oe_n               = st_r.goe_n;
  assign lock_detect_n           = st_r.lock_n;
  assign hot_plug_detect_n       = st_r.hpd_n;
  assign lock_from_backchannel   = st_r.lock_bc;
  assign bc_master_side          = st_r.master;
  assign i2c_is_slave            = st_r.i2c_slave;
  assign serial_addr             = st_r.addr;
  assign serial_addr_bad         = st_r.addr_bad;
  assign lane_mode               = st_r.lane;
  assign sublink_power_on        = st_r.sub_on;
  assign mainlink_power_on       = st_r.main_on;
  assign emphasis_full           = st_r.emph;
  assign width_24bit             = st_r.w24;
  assign in_field_bit_error_test = st_r.test;
  assign sel_de                  = st_r.de;
  assign send_video              = st_r.video;
endmodule
`default_nettype wire
